// ### rtl/gel_port.sv
// GPIO edge event and LED port top level
// Operation
// - Config bit 0 direction, bit 1 polarity
// - Config bit 7 selects open-drain or push-pull
// - One data bit per pin, six banks
// - Input read returns pin, polarity applied
// - Writes to input data bits ignored
// - Output drives written data, polarity applied
// - Output read returns last written value
// - Output pins excluded from event logic, except pins 9 and 10
// - Output-only pins: config bits 0,7 fixed
// - Polarity picks wake edge, default rising
// - Wake and button status/enable sets
// - Management interrupt status/enable sets three, four
// - Either-edge mode ignores direction, polarity, driver
// - Either-edge: polarity still inverts read data
// - Either-edge interrupt needs mode and enable
// - Either-edge status on every transition, W1C
// - Misc status collects either-edge bits, W1C
// - Either-edge status records regardless of enables
// - Two LED registers at 0x5d, 0x5e
// - LED logic runs on standby clock
// - Dedicated LED pins drive open-drain only
// - S5 option forces LED to bit 2
// - S5 level non-inverted; pin config polarity
// - Output-only pins never inputs; dedicated LED pins open-drain
`timescale 1ns/1ps
`default_nettype none
`include "gel_params.svh"
module gel_port
#(
    parameter int unsigned BLINK_CYCLES = `GEL_BLINK_CYCLES
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [`GEL_PIN_COUNT-1:0] pin_i,
    output logic [`GEL_PIN_COUNT-1:0] pin_o,
    output logic [`GEL_PIN_COUNT-1:0] pin_oe_o,
    input wire logic s5_sleep_n_i,
    output logic wake_o,
    output logic button_wake_o,
    output logic mgmt_irq_o
);
    import gel_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    localparam int NP = `GEL_PIN_COUNT;
    gel_byte_t cfg_q [NP];
    logic [NP-1:0] data_q;
    logic [NP-1:0] samp_q;
    logic [7:0] rdata_q;
    logic [7:0] wsts3_q, wen3_q, bsts3_q, ben3_q;
    logic [7:0] wsts5_q, wen5_q, bsts5_q, ben5_q;
    logic [7:0] msts3_q, men3_q, msts4_q, men4_q;
    logic [7:0] misc_q, esel_q;
    gel_byte_t led_one_q, led_two_q;
    logic [31:0] blink_cnt_q;
    logic blink_q;

    // ****************************************
    // Decode and pin view
    // ****************************************
    wire cfg_hit = reg_addr_i < 8'(NP);
    wire data_hit = (reg_addr_i >= `GEL_OFF_DATA_BASE) &&
        (reg_addr_i < `GEL_OFF_DATA_BASE + 8'(`GEL_BANK_COUNT));
    wire [2:0] bank = 3'(reg_addr_i - `GEL_OFF_DATA_BASE);
    wire wr_ok = reg_wr_i;
    logic [NP-1:0] is_in, pol, od, dual, pin_view, rise, fall, ev;
    logic [NP-1:0] rd_view;

    generate
        for (genvar p = 0; p < NP; p++)
        begin : g_pin
            wire is_dual = (p == `GEL_PIN_DUAL_A) && esel_q[0] ||
                (p == `GEL_PIN_DUAL_B) && esel_q[1];
            assign dual[p] = is_dual;
            // Either-edge pins act as inputs whatever direction says
            assign is_in[p] = cfg_q[p][`GEL_CFG_DIR_BIT] | is_dual;
            assign pol[p] = cfg_q[p][`GEL_CFG_POL_BIT];
            assign od[p] = cfg_q[p][`GEL_CFG_OD_BIT];
            assign pin_view[p] = pin_i[p] ^ pol[p];
            // Input read shows pin, output read shows last write
            assign rd_view[p] = is_in[p] ? pin_view[p] : data_q[p];
            // Polarity chosen edge: rising on corrected level
            assign rise[p] = is_in[p] & ~(samp_q[p] ^ pol[p]) &
                pin_view[p];
            assign fall[p] = pin_i[p] ^ samp_q[p];
            // Dual pins log both edges in any mode; other outputs log nothing
            assign ev[p] = (p == `GEL_PIN_DUAL_A || p == `GEL_PIN_DUAL_B) ?
                fall[p] : rise[p] & ~dual[p];
        end
    endgenerate

    // ****************************************
    // Event grouping
    // ****************************************
    wire [7:0] ev3 = {3'h0, ev[`GEL_PIN_W33], ev[`GEL_PIN_W32],
        ev[`GEL_PIN_W27], ev[`GEL_PIN_DUAL_B], ev[`GEL_PIN_DUAL_A]};
    wire [7:0] ev5 = ev[`GEL_PIN_BANK5 +: 8];
    wire [7:0] evm3 = {2'h0, ev[`GEL_PIN_BANK5+7 -: 4],
        ev[`GEL_PIN_DUAL_B], ev[`GEL_PIN_DUAL_A]};
    wire [7:0] evm4 = {5'h0, ev[`GEL_PIN_W42], ev[`GEL_PIN_W33],
        ev[`GEL_PIN_W32]};
    wire [7:0] evx = {6'h0, ev[`GEL_PIN_DUAL_B], ev[`GEL_PIN_DUAL_A]};
    // Dual pins raise requests only in either-edge mode
    wire [7:0] gate3 = {6'h3f, esel_q[1], esel_q[0]};
    wire [7:0] wr_b = wr_ok ? reg_wdata_i : 8'h00;
    function automatic logic [7:0] w1c(input logic [7:0] cur,
        input logic [7:0] set, input logic hit, input logic [7:0] wb);
        // Set beats clear in the same cycle
        w1c = set | (cur & ~(hit ? wb : 8'h00));
    endfunction : w1c

    wire [7:0] wsts3_d = w1c(wsts3_q, ev3,
        reg_addr_i == `GEL_OFF_WAKE_STS3, wr_b);
    wire [7:0] bsts3_d = w1c(bsts3_q, ev3,
        reg_addr_i == `GEL_OFF_BTN_STS3, wr_b);
    wire [7:0] wsts5_d = w1c(wsts5_q, ev5,
        reg_addr_i == `GEL_OFF_WAKE_STS5, wr_b);
    wire [7:0] bsts5_d = w1c(bsts5_q, ev5,
        reg_addr_i == `GEL_OFF_BTN_STS5, wr_b);
    wire [7:0] msts3_d = w1c(msts3_q, evm3,
        reg_addr_i == `GEL_OFF_MGMT_STS3, wr_b);
    wire [7:0] msts4_d = w1c(msts4_q, evm4,
        reg_addr_i == `GEL_OFF_MGMT_STS4, wr_b);
    wire [7:0] misc_d = w1c(misc_q, evx,
        reg_addr_i == `GEL_OFF_MISC_STS, wr_b);

    // ****************************************
    // Read mux
    // ****************************************
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        if (cfg_hit)
            rd_mux = cfg_q[reg_addr_i[5:0]];
        else if (data_hit)
            rd_mux = rd_view[{bank, 3'h0} +: 8];
        else
            unique case (reg_addr_i)
                `GEL_OFF_WAKE_STS3: rd_mux = wsts3_q;
                `GEL_OFF_WAKE_EN3: rd_mux = wen3_q;
                `GEL_OFF_BTN_STS3: rd_mux = bsts3_q;
                `GEL_OFF_BTN_EN3: rd_mux = ben3_q;
                `GEL_OFF_WAKE_STS5: rd_mux = wsts5_q;
                `GEL_OFF_WAKE_EN5: rd_mux = wen5_q;
                `GEL_OFF_BTN_STS5: rd_mux = bsts5_q;
                `GEL_OFF_BTN_EN5: rd_mux = ben5_q;
                `GEL_OFF_MGMT_STS3: rd_mux = msts3_q;
                `GEL_OFF_MGMT_EN3: rd_mux = men3_q;
                `GEL_OFF_MGMT_STS4: rd_mux = msts4_q;
                `GEL_OFF_MGMT_EN4: rd_mux = men4_q;
                `GEL_OFF_MISC_STS: rd_mux = misc_q;
                `GEL_OFF_EDGE_SEL: rd_mux = esel_q;
                `GEL_OFF_LED_ONE: rd_mux = led_one_q;
                `GEL_OFF_LED_TWO: rd_mux = led_two_q;
                default: rd_mux = 8'h00;
            endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int p = 0; p < NP; p++)
                cfg_q[p] <= (p < 8 || p == `GEL_PIN_LED_ONE_OD ||
                    p == `GEL_PIN_LED_TWO_OD) ? `GEL_CFG_OUT_RESET :
                    `GEL_CFG_RESET;
        end
        else if (wr_ok && cfg_hit)
        begin
            for (int p = 0; p < NP; p++)
                if (reg_addr_i[5:0] == 6'(p))
                begin
                    cfg_q[p] <= reg_wdata_i;
                    // Output-only and dedicated LED pins keep direction and drive fixed
                    if (p < 8 || p == `GEL_PIN_LED_ONE_OD ||
                        p == `GEL_PIN_LED_TWO_OD)
                    begin
                        cfg_q[p][`GEL_CFG_DIR_BIT] <= 1'b0;
                        cfg_q[p][`GEL_CFG_OD_BIT] <= 1'b1;
                    end
                end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            data_q <= '0;
        else if (wr_ok && data_hit)
            for (int b = 0; b < 8; b++)
                if (!is_in[{bank, 3'h0} + 6'(b)])
                    data_q[{bank, 3'h0} + 6'(b)] <= reg_wdata_i[b];
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            samp_q <= '0;
            rdata_q <= 8'h00;
        end
        else
        begin
            samp_q <= pin_i;
            if (reg_rd_i)
                rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            {wsts3_q, bsts3_q, wsts5_q, bsts5_q} <= '0;
            {msts3_q, msts4_q, misc_q} <= '0;
        end
        else
        begin
            wsts3_q <= wsts3_d;
            bsts3_q <= bsts3_d;
            wsts5_q <= wsts5_d;
            bsts5_q <= bsts5_d;
            msts3_q <= msts3_d;
            msts4_q <= msts4_d;
            misc_q <= misc_d;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            {wen3_q, ben3_q, wen5_q, ben5_q, men3_q, men4_q} <= '0;
            {esel_q, led_one_q, led_two_q} <= '0;
        end
        else if (wr_ok)
        begin
            unique case (reg_addr_i)
                `GEL_OFF_WAKE_EN3: wen3_q <= reg_wdata_i;
                `GEL_OFF_BTN_EN3: ben3_q <= reg_wdata_i;
                `GEL_OFF_WAKE_EN5: wen5_q <= reg_wdata_i;
                `GEL_OFF_BTN_EN5: ben5_q <= reg_wdata_i;
                `GEL_OFF_MGMT_EN3: men3_q <= reg_wdata_i;
                `GEL_OFF_MGMT_EN4: men4_q <= reg_wdata_i;
                `GEL_OFF_EDGE_SEL: esel_q <= {6'h00, reg_wdata_i[1:0]};
                `GEL_OFF_LED_ONE: led_one_q <= reg_wdata_i;
                `GEL_OFF_LED_TWO: led_two_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ****************************************
    // LED blink and pin drive
    // ****************************************
    // LED one rate field scales the shared half period; clock runs on standby power
    wire [31:0] half = BLINK_CYCLES >> led_one_q[`GEL_LED_RATE_LSB +: 2];
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else if (blink_cnt_q + 32'h1 >= half)
        begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 32'h1;
    end

    function automatic logic led_lvl(input gel_byte_t r, input logic bl,
        input logic s5n);
        gel_led_mode_t m;
        m = gel_led_mode_t'(r[`GEL_LED_MODE_LSB +: 2]);
        if (r[`GEL_LED_S5_EN_BIT] && !s5n)
            led_lvl = r[`GEL_LED_S5_LEVEL_BIT];
        else
            led_lvl = (m == GEL_LED_ON) || (m == GEL_LED_BLINK && bl);
    endfunction : led_lvl

    wire led_one_lvl = led_lvl(led_one_q, blink_q, s5_sleep_n_i);
    wire led_two_lvl = led_lvl(led_two_q, blink_q, s5_sleep_n_i);
    wire led_one_on = led_one_q[1:0] != 2'h0 || led_one_q[`GEL_LED_S5_EN_BIT];
    wire led_two_on = led_two_q[1:0] != 2'h0 || led_two_q[`GEL_LED_S5_EN_BIT];

    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            logic lv;
            lv = data_q[p];
            if (led_one_on && (p == `GEL_PIN_LED_ONE_OD ||
                p == `GEL_PIN_LED_ONE_ALT))
                lv = led_one_lvl;
            if (led_two_on && (p == `GEL_PIN_LED_TWO_OD ||
                p == `GEL_PIN_LED_TWO_ALT))
                lv = led_two_lvl;
            lv = lv ^ pol[p];
            pin_o[p] = od[p] ? 1'b0 : lv;
            pin_oe_o[p] = !is_in[p] && (od[p] ? !lv : 1'b1);
        end
    end

    // ****************************************
    // Event outputs
    // ****************************************
    assign wake_o = |(wsts3_q & wen3_q & gate3) | |(wsts5_q & wen5_q);
    assign button_wake_o = |(bsts3_q & ben3_q & gate3) | |(bsts5_q & ben5_q);
    assign mgmt_irq_o = |(msts3_q & men3_q & gate3) | |(msts4_q & men4_q);
    assign reg_rdata_o = rdata_q;
endmodule : gel_port
`default_nettype wire

// ### rtl/gel_params.svh
// Constants for the GPIO edge event and LED port
`ifndef GEL_PARAMS_SVH
`define GEL_PARAMS_SVH
`define GEL_PIN_COUNT 48
`define GEL_BANK_COUNT 6
`define GEL_CFG_DIR_BIT 0
`define GEL_CFG_POL_BIT 1
`define GEL_CFG_OD_BIT 7
`define GEL_CFG_RESET 8'h01
`define GEL_CFG_OUT_RESET 8'h80
`define GEL_OFF_LED_ONE 8'h5d
`define GEL_OFF_LED_TWO 8'h5e
`define GEL_OFF_CFG_BASE 8'h00
`define GEL_OFF_DATA_BASE 8'h30
`define GEL_OFF_WAKE_STS3 8'h38
`define GEL_OFF_WAKE_EN3 8'h39
`define GEL_OFF_BTN_STS3 8'h3a
`define GEL_OFF_BTN_EN3 8'h3b
`define GEL_OFF_WAKE_STS5 8'h3c
`define GEL_OFF_WAKE_EN5 8'h3d
`define GEL_OFF_BTN_STS5 8'h3e
`define GEL_OFF_BTN_EN5 8'h3f
`define GEL_OFF_MGMT_STS3 8'h50
`define GEL_OFF_MGMT_EN3 8'h51
`define GEL_OFF_MGMT_STS4 8'h52
`define GEL_OFF_MGMT_EN4 8'h53
`define GEL_OFF_MISC_STS 8'h54
`define GEL_OFF_EDGE_SEL 8'h55
`define GEL_LED_MODE_LSB 0
`define GEL_LED_S5_LEVEL_BIT 2
`define GEL_LED_S5_EN_BIT 3
`define GEL_LED_RATE_LSB 4
`define GEL_BLINK_HALF_NS 500000000
`define GEL_CLK_NS 10
`define GEL_BLINK_CYCLES (`GEL_BLINK_HALF_NS / `GEL_CLK_NS)
// Pin indices: bank*8 + bit
`define GEL_PIN_DUAL_A 9
`define GEL_PIN_DUAL_B 10
`define GEL_PIN_W27 15
`define GEL_PIN_W32 17
`define GEL_PIN_W33 18
`define GEL_PIN_W42 26
`define GEL_PIN_BANK5 32
`define GEL_PIN_LED_ONE_ALT 33
`define GEL_PIN_LED_TWO_ALT 38
`define GEL_PIN_LED_ONE_OD 40
`define GEL_PIN_LED_TWO_OD 41
`endif

// ### rtl/gel_pkg.sv
// Types for the GPIO edge event and LED port
package gel_pkg;
    typedef enum logic [1:0] {GEL_LED_OFF, GEL_LED_ON, GEL_LED_BLINK,
        GEL_LED_RSVD} gel_led_mode_t;
    typedef logic [7:0] gel_byte_t;
endpackage : gel_pkg

// ### test/gel_port_chk.sv
// Port checker for the GPIO edge event and LED port
`timescale 1ns/1ps
`default_nettype none
`include "gel_params.svh"
module gel_port_chk
#(
    parameter int unsigned BLINK_CYCLES = 8
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [`GEL_PIN_COUNT-1:0] pin_i,
    input wire logic [`GEL_PIN_COUNT-1:0] pin_o,
    input wire logic wake_o,
    input wire logic button_wake_o,
    input wire logic mgmt_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ************************************************
    // Cycles since the last pin change or write
    // ************************************************
    logic [`GEL_PIN_COUNT-1:0] pin_prev_q;
    logic [2:0] quiet_q;
    always_ff @(posedge sys_clk_i)
    begin
        pin_prev_q <= pin_i;
        if (rst_i || reg_wr_i || pin_i != pin_prev_q)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    // ************************************************
    // Properties
    // ************************************************
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i > 8'h5e |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_sticky: assert property (
        reg_rd_i && (reg_addr_i < 8'h08 || reg_addr_i inside {8'h28, 8'h29})
        |=> !reg_rdata_o[0] && reg_rdata_o[7])
        else $error("fixed config bits changed");
    a_od_pins_low: assert property (
        pin_o[7:0] == 8'h00 && pin_o[41:40] == 2'b00)
        else $error("open-drain pin driven high");
    a_misc_bits: assert property (
        reg_rd_i && reg_addr_i == `GEL_OFF_MISC_STS
        |=> reg_rdata_o[7:2] == 6'h00)
        else $error("misc status has stray bits");
    // Events need a pin change or a write shortly before
    a_wake_cause: assert property ($rose(wake_o) |-> quiet_q < 3'h4)
        else $error("wake raised without cause");
    a_button_cause: assert property (
        $rose(button_wake_o) |-> quiet_q < 3'h4)
        else $error("button wake raised without cause");
    a_irq_fall: assert property ($fell(mgmt_irq_o) |-> $past(reg_wr_i))
        else $error("interrupt dropped without a write");
endmodule : gel_port_chk
bind gel_port gel_port_chk #(.BLINK_CYCLES(BLINK_CYCLES)) gel_port_chk_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pin_i(pin_i), .pin_o(pin_o), .wake_o(wake_o),
    .button_wake_o(button_wake_o), .mgmt_irq_o(mgmt_irq_o));
`default_nettype wire

// ### test/gel_port_bench.sv
// Self-checking bench for the GPIO edge event and LED port
`timescale 1ns/1ps
`default_nettype none
`include "gel_params.svh"
module gel_port_bench;
    import gel_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic s5n = 1'b1;
    logic [47:0] pin = 48'h0;
    logic [7:0] rdat;
    logic [47:0] po;
    logic [47:0] poe;
    logic wk, bw, mi;
    int failures = 0;
    int checked = 0;
    logic [31:0] seed = 32'hcc73;
    gel_byte_t v;
    gel_byte_t cfg [8];
    logic [23:0] e;
    int b, n;
    gel_port #(.BLINK_CYCLES(8)) gel_port_inst (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .pin_i(pin), .pin_o(po),
        .pin_oe_o(poe), .s5_sleep_n_i(s5n), .wake_o(wk),
        .button_wake_o(bw), .mgmt_irq_o(mi));
    always #5 sys_clk_i = ~sys_clk_i;
    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Returns {read data, output enable, output level} of one bank
    function automatic logic [23:0] bank_exp(input gel_byte_t c [8],
        input logic [7:0] p, input logic [7:0] d);
        logic [23:0] r;
        r = 24'h0;
        for (int i = 0; i < 8; i++)
        begin
            r[16+i] = c[i][0] ? p[i] ^ c[i][1] : d[i];
            r[8+i] = !c[i][0] && !(c[i][7] && (d[i] ^ c[i][1]));
            r[i] = !c[i][0] && !c[i][7] && (d[i] ^ c[i][1]);
        end
        return r;
    endfunction : bank_exp
    task automatic cmp(input string nm, input logic [7:0] x, input logic [7:0] g);
        checked++;
        if (g !== x)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask : cmp
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge sys_clk_i);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output gel_byte_t r);
        @(negedge sys_clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk_i);
        rd = 1'b0;
        r = rdat;
    endtask : rd_reg
    // Moves one pin, checks a status bit and an event output, then clears
    task automatic ev(input int p, input logic l, input logic [7:0] a,
        input logic [7:0] m, input logic x, input int k, input logic xo);
        gel_byte_t r;
        pin[p] = l;
        repeat (4) @(negedge sys_clk_i);
        rd_reg(a, r);
        cmp("status", {8{x}} & m, r & m);
        cmp("event_out", {7'h0, xo},
            {7'h0, (k == 0) ? wk : (k == 1) ? bw : mi});
        wr_reg(a, m);
    endtask : ev
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #200000;
        failures++;
        tally_and_finish();
    end
    // ************************************************
    // Tests
    // ************************************************
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int p = 0; p < 48; p++)
        begin
            rd_reg(8'(p), v);
            cmp("cfg_reset", (p < 8 || p > 39 && p < 42) ? 8'h80 : 8'h01, v);
        end
        wr_reg(8'h03, 8'h03);
        rd_reg(8'h03, v);
        cmp("cfg_fixed", 8'h82, v);
        wr_reg(8'h28, 8'h01);
        rd_reg(8'h28, v);
        cmp("cfg_fixed", 8'h80, v);
        rd_reg(8'h70, v);
        cmp("unmapped", 8'h00, v);
        $display("test config done");
        for (int r = 0; r < 16; r++)
        begin
            b = 1 + r % 4;
            for (int i = 0; i < 8; i++)
            begin
                seed = lfsr(seed);
                cfg[i] = {seed[2], 5'h00, seed[1:0]};
                wr_reg(8'(b * 8 + i), cfg[i]);
            end
            seed = lfsr(seed);
            pin[b*8 +: 8] = seed[15:8];
            wr_reg(8'h30 + 8'(b), seed[7:0]);
            rd_reg(8'h30 + 8'(b), v);
            e = bank_exp(cfg, seed[15:8], seed[7:0]);
            cmp("data", e[23:16], v);
            cmp("pin_oe", e[15:8], poe[b*8 +: 8]);
            cmp("pin_o", e[7:0], po[b*8 +: 8] & e[15:8]);
        end
        $display("test data done");
        pin = 48'h0;
        wr_reg(8'h0f, 8'h01);
        wr_reg(8'h20, 8'h01);
        wr_reg(8'h09, 8'h01);
        for (int a = 8'h38; a < 8'h3f; a += 2)
            wr_reg(8'(a), 8'hff);
        wr_reg(8'h50, 8'hff);
        wr_reg(8'h54, 8'hff);
        wr_reg(8'h39, 8'h04);
        wr_reg(8'h3f, 8'h01);
        wr_reg(8'h51, 8'h01);
        ev(15, 1'b1, 8'h38, 8'h04, 1'b1, 0, 1'b1);
        ev(15, 1'b0, 8'h38, 8'h04, 1'b0, 0, 1'b0);
        ev(32, 1'b1, 8'h3e, 8'h01, 1'b1, 1, 1'b1);
        wr_reg(8'h0f, 8'h03);
        wr_reg(8'h38, 8'h04);
        ev(15, 1'b1, 8'h38, 8'h04, 1'b0, 0, 1'b0);
        ev(15, 1'b0, 8'h38, 8'h04, 1'b1, 0, 1'b1);
        wr_reg(8'h0f, 8'h00);
        wr_reg(8'h38, 8'h04);
        ev(15, 1'b1, 8'h38, 8'h04, 1'b0, 0, 1'b0);
        ev(15, 1'b0, 8'h38, 8'h04, 1'b0, 0, 1'b0);
        ev(9, 1'b1, 8'h54, 8'h01, 1'b1, 2, 1'b0);
        ev(9, 1'b0, 8'h54, 8'h01, 1'b1, 2, 1'b0);
        wr_reg(8'h55, 8'h01);
        wr_reg(8'h09, 8'h83);
        wr_reg(8'h50, 8'h01);
        ev(9, 1'b1, 8'h50, 8'h01, 1'b1, 2, 1'b1);
        ev(9, 1'b0, 8'h50, 8'h01, 1'b1, 2, 1'b1);
        rd_reg(8'h31, v);
        cmp("data_pol", 8'h02, v & 8'h02);
        wr_reg(8'h55, 8'h00);
        $display("test events done");
        wr_reg(8'h21, 8'h00);
        wr_reg(8'h26, 8'h00);
        s5n = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(8'h5d + 8'(k / 2), 8'h08 | 8'(k % 2) << 2);
            rd_reg(8'h5d + 8'(k / 2), v);
            cmp("led_reg", 8'h08 | 8'(k % 2) << 2, v);
            b = k < 2 ? 33 : 38;
            cmp("led_alt", 8'(k % 2), {7'h0, po[b] & poe[b]});
            cmp("led_od", 8'(1 - k % 2), {7'h0, poe[40 + k / 2]});
        end
        s5n = 1'b1;
        wr_reg(8'h5d, 8'h02);
        n = 0;
        for (int c = 0; c < 40; c++)
        begin
            v[0] = poe[40];
            @(negedge sys_clk_i);
            n += (poe[40] !== v[0]);
        end
        cmp("blink", 8'h01, {7'h0, n >= 3});
        $display("test led done");
        tally_and_finish();
    end
endmodule : gel_port_bench
`default_nettype wire
